// ===== src/ctc_pkg.sv
// Package of constants and types for the processor timer and clock comparator
// Function
// - Timer counts down elapsed time and requests an interruption when period ends.
// - Timer decrements while processor operates and while it waits.
// - Timer holds its value while processor is stopped.
// - Store-timer returns current timer contents without changing the count.
// - Set-timer loads the timer with the program's operand.
// - Initial processor reset clears the timer to zero.
// - Timer does not decrement while time-of-day clock is stopped or in error.
// - Comparator requests an interruption when time-of-day clock reaches comparison value.
// - Comparator request presented only with control bit 20 and external mask set.
// - Comparison register has the time-of-day clock's format for direct compare.
// - Comparator interruption belongs to the external interruption class.
// - Store-comparator returns comparison value; set-comparator loads a new one.
// - Initial processor reset clears the comparison value to zero.
// - Comparator idle, no request, while time-of-day clock stopped or in error.
// - Timer condition exists while negative; presented with control bit 21 and mask.
package ctc_pkg;
	// Register byte offsets
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_STATUS = 5'h04;
	localparam logic [4:0] OFS_MASK = 5'h08;
	localparam logic [4:0] OFS_STATE = 5'h0C;
	localparam logic [4:0] OFS_TMR_LO = 5'h10;
	localparam logic [4:0] OFS_TMR_HI = 5'h14;
	localparam logic [4:0] OFS_CMP_LO = 5'h18;
	localparam logic [4:0] OFS_CMP_HI = 5'h1C;
	// Control register fields
	localparam int CTRL_EXT_MASK = 0;
	localparam int CTRL_CMP_EN = 20;
	localparam int CTRL_TMR_EN = 21;
	localparam logic [31:0] CTRL_WMASK = 32'h0030_0001;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// Event and state bit positions
	localparam int EV_TMR = 0;
	localparam int EV_CMP = 1;
	localparam int ST_RUN = 2;
	localparam int ST_TOD_OK = 3;
	localparam int EV_W = 2;
	localparam logic [EV_W-1:0] EV_RST = 2'h0;
	// Value widths and reset values
	localparam int VAL_W = 64;
	localparam logic [63:0] TMR_RST = 64'h0000_0000_0000_0000;
	localparam logic [63:0] CMP_RST = 64'h0000_0000_0000_0000;
	// Processor run state
	typedef enum logic [1:0] {
		CPU_OPERATING = 2'b00,
		CPU_WAITING = 2'b01,
		CPU_STOPPED = 2'b10,
		CPU_CHECKSTOP = 2'b11
	} ctc_cpu_t;
	// Time-of-day clock state
	typedef enum logic [1:0] {
		TOD_SET = 2'b00,
		TOD_NOT_SET = 2'b01,
		TOD_STOPPED = 2'b10,
		TOD_ERROR = 2'b11
	} ctc_tod_t;
	// Environment from processor core and time-of-day clock
	typedef struct packed {
		ctc_cpu_t cpu_state;
		ctc_tod_t tod_state;
		logic tod_step;
		logic init_reset;
	} ctc_env_t;
	// Presented external interruption requests
	typedef struct packed {
		logic ext_req;
		logic tmr_req;
		logic cmp_req;
	} ctc_ext_t;
endpackage

// ===== src/ctc_timer_cnt.sv
// Loadable down counter holding the processor timer value
`timescale 1ns/1ps
module ctc_timer_cnt #(
	parameter int W = 64
) (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Control
	input wire logic clr,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic dec,
	// Value
	output logic [W-1:0] value
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Clear beats load, load beats a decrement in the same cycle
	assign cnt_nxt = clr ? ctc_pkg::TMR_RST[W-1:0] :
		load ? load_val :
		dec ? cnt_r - {{(W-1){1'b0}}, 1'b1} :
		cnt_r;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			cnt_r <= ctc_pkg::TMR_RST[W-1:0];
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign value = cnt_r;
endmodule

// ===== src/ctc_top.sv
// Processor timer and clock comparator with Avalon-MM register access
`timescale 1ns/1ps
module ctc_top (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Avalon-MM slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Processor core and time-of-day clock
	input wire ctc_pkg::ctc_env_t env,
	input wire logic [63:0] tod_value,
	// Interruption outputs
	output ctc_pkg::ctc_ext_t ext_int,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Merge write data into a word under the byte enables
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic ack_r;
	logic [31:0] rdata_r;
	logic [31:0] ctrl_r;
	logic [31:0] ctrl_nxt;
	logic [ctc_pkg::EV_W-1:0] status_r;
	logic [ctc_pkg::EV_W-1:0] status_nxt;
	logic [ctc_pkg::EV_W-1:0] mask_r;
	logic [ctc_pkg::EV_W-1:0] mask_nxt;
	logic [31:0] tmr_hi_stage_r;
	logic [31:0] tmr_hi_snap_r;
	logic [31:0] cmp_hi_stage_r;
	logic [63:0] cmp_r;
	logic [63:0] cmp_nxt;
	logic [63:0] tmr_val;
	logic tmr_neg_r;
	logic cmp_cond_r;
	ctc_pkg::ctc_ext_t ext_r;
	ctc_pkg::ctc_ext_t ext_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake: every access takes exactly one wait cycle
	wire req = avs_read | avs_write;
	wire acc = req & ack_r;
	wire rd_first = avs_read & ~ack_r;
	wire wr_acc = avs_write & ack_r;
	assign avs_waitrequest = req & ~ack_r;
	assign avs_readdata = rdata_r;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Address decode
	wire sel_ctrl = avs_address == ctc_pkg::OFS_CTRL;
	wire sel_status = avs_address == ctc_pkg::OFS_STATUS;
	wire sel_mask = avs_address == ctc_pkg::OFS_MASK;
	wire sel_state = avs_address == ctc_pkg::OFS_STATE;
	wire sel_tlo = avs_address == ctc_pkg::OFS_TMR_LO;
	wire sel_thi = avs_address == ctc_pkg::OFS_TMR_HI;
	wire sel_clo = avs_address == ctc_pkg::OFS_CMP_LO;
	wire sel_chi = avs_address == ctc_pkg::OFS_CMP_HI;

	////////////////////////////////////////////////////////////////////////////
	// Run conditions
	wire tod_ok = (env.tod_state == ctc_pkg::TOD_SET) |
		(env.tod_state == ctc_pkg::TOD_NOT_SET);
	wire cpu_runs = (env.cpu_state == ctc_pkg::CPU_OPERATING) |
		(env.cpu_state == ctc_pkg::CPU_WAITING);
	wire tmr_dec = env.tod_step & cpu_runs & tod_ok;
	wire ext_mask = ctrl_r[ctc_pkg::CTRL_EXT_MASK];
	wire tmr_en = ctrl_r[ctc_pkg::CTRL_TMR_EN];
	wire cmp_en = ctrl_r[ctc_pkg::CTRL_CMP_EN];

	////////////////////////////////////////////////////////////////////////////
	// Processor timer
	// A low-word write commits the staged high word, so the 64-bit load is atomic
	wire tmr_load = wr_acc & sel_tlo;
	wire [31:0] tmr_lo_new = be_merge(tmr_val[31:0], avs_writedata, avs_byteenable);

	ctc_timer_cnt #(
		.W(ctc_pkg::VAL_W)
	) u_cnt (
		.clock(clock),
		.nrst(nrst),
		.clr(env.init_reset),
		.load(tmr_load),
		.load_val({tmr_hi_stage_r, tmr_lo_new}),
		.dec(tmr_dec),
		.value(tmr_val)
	);

	// High-word staging for set, snapshot for store
	always_ff @(posedge clock) begin
		if (!nrst) begin
			tmr_hi_stage_r <= ctc_pkg::TMR_RST[63:32];
		end else if (wr_acc & sel_thi) begin
			tmr_hi_stage_r <= be_merge(tmr_hi_stage_r, avs_writedata, avs_byteenable);
		end
	end

	// Reading the low word freezes the high word so the pair is coherent
	always_ff @(posedge clock) begin
		if (!nrst) begin
			tmr_hi_snap_r <= ctc_pkg::TMR_RST[63:32];
		end else if (rd_first & sel_tlo) begin
			tmr_hi_snap_r <= tmr_val[63:32];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Clock comparator, same layout as the time-of-day clock value
	wire [31:0] cmp_lo_new = be_merge(cmp_r[31:0], avs_writedata, avs_byteenable);
	assign cmp_nxt = env.init_reset ? ctc_pkg::CMP_RST :
		(wr_acc & sel_clo) ? {cmp_hi_stage_r, cmp_lo_new} :
		cmp_r;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			cmp_r <= ctc_pkg::CMP_RST;
		end else begin
			cmp_r <= cmp_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			cmp_hi_stage_r <= ctc_pkg::CMP_RST[63:32];
		end else if (wr_acc & sel_chi) begin
			cmp_hi_stage_r <= be_merge(cmp_hi_stage_r, avs_writedata, avs_byteenable);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interruption conditions, registered one cycle after their cause
	// A stopped or failed time-of-day clock kills the comparator condition outright
	wire tmr_cond = tmr_val[63];
	wire cmp_cond = tod_ok & (tod_value >= cmp_r);

	always_ff @(posedge clock) begin
		if (!nrst) begin
			tmr_neg_r <= 1'b0;
			cmp_cond_r <= 1'b0;
		end else begin
			tmr_neg_r <= tmr_cond;
			cmp_cond_r <= cmp_cond;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Presentation: conditions stay pending and show once both enables are set
	assign ext_nxt.tmr_req = tmr_neg_r & tmr_en & ext_mask;
	assign ext_nxt.cmp_req = cmp_cond_r & cmp_en & ext_mask;
	assign ext_nxt.ext_req = ext_nxt.tmr_req | ext_nxt.cmp_req;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			ext_r <= '0;
		end else begin
			ext_r <= ext_nxt;
		end
	end

	assign ext_int = ext_r;

	////////////////////////////////////////////////////////////////////////////
	// Control and mask registers
	assign ctrl_nxt = (wr_acc & sel_ctrl) ?
		(be_merge(ctrl_r, avs_writedata, avs_byteenable) & ctc_pkg::CTRL_WMASK) : ctrl_r;
	wire [31:0] mask_word = be_merge({{(32-ctc_pkg::EV_W){1'b0}}, mask_r}, avs_writedata,
		avs_byteenable);
	assign mask_nxt = (wr_acc & sel_mask) ? mask_word[ctc_pkg::EV_W-1:0] : mask_r;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			ctrl_r <= ctc_pkg::CTRL_RST;
			mask_r <= ctc_pkg::EV_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
			mask_r <= mask_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky status: set on a rising condition, cleared by writing one
	// A new event in the clearing cycle survives, since set is applied last
	wire [ctc_pkg::EV_W-1:0] ev_rise = {cmp_cond & ~cmp_cond_r, tmr_cond & ~tmr_neg_r};
	wire [ctc_pkg::EV_W-1:0] w1c = (wr_acc & sel_status & avs_byteenable[0]) ?
		avs_writedata[ctc_pkg::EV_W-1:0] : {ctc_pkg::EV_W{1'b0}};
	assign status_nxt = (status_r & ~w1c) | ev_rise;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			status_r <= ctc_pkg::EV_RST;
		end else begin
			status_r <= status_nxt;
		end
	end

	// Level interrupt while any unmasked status bit is set
	always_ff @(posedge clock) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_nxt & mask_nxt);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path, captured at the first cycle of a read
	wire [31:0] state_word = {28'h000_0000, tod_ok, cpu_runs, cmp_cond_r, tmr_neg_r};
	wire [31:0] rmux = sel_ctrl ? ctrl_r :
		sel_status ? {{(32-ctc_pkg::EV_W){1'b0}}, status_r} :
		sel_mask ? {{(32-ctc_pkg::EV_W){1'b0}}, mask_r} :
		sel_state ? state_word :
		sel_tlo ? tmr_val[31:0] :
		sel_thi ? tmr_hi_snap_r :
		sel_clo ? cmp_r[31:0] :
		sel_chi ? cmp_r[63:32] :
		32'h0000_0000;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			rdata_r <= 32'h0000_0000;
		end else if (rd_first) begin
			rdata_r <= rmux;
		end
	end

	// Unused request qualifier kept for symmetry with the write path
	wire unused_acc = acc;
endmodule

// ===== verification/ctc_assertions.sv
// Checker of bus timing and interruption outputs of the timer block
`timescale 1ns/1ps
module ctc_assertions (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Bus and environment
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire ctc_pkg::ctc_env_t env,
	// Interruption outputs
	input wire ctc_pkg::ctc_ext_t ext_int,
	input wire logic irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////////////
	// Bus answers after exactly one wait cycle, never when idle
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest held past one cycle");
	a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest without request");
	// Read data only move after a read
	a_rd_stable: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without read");
	// Both requests belong to the external class
	a_ext_class: assert property (ext_int.ext_req == (ext_int.tmr_req || ext_int.cmp_req))
		else $error("external request does not match sources");
	// Comparator silent while the clock is stopped or broken
	a_cmp_tod_bad: assert property (env.tod_state[1] [*3] |-> !ext_int.cmp_req)
		else $error("comparator request with clock not running");
	a_cmp_rise_ok: assert property ($rose(ext_int.cmp_req) |-> !$past(env.tod_state[1], 2))
		else $error("comparator request rose from a stopped clock");
	// Initial reset clears the timer, so its request drops
	a_init_clear: assert property (env.init_reset |-> ##3 !ext_int.tmr_req)
		else $error("timer request survived initial reset");
	a_rst_quiet: assert property ($rose(nrst) |-> ext_int == 3'h0 && !irq && avs_readdata == 32'h0)
		else $error("outputs not quiet after reset");
endmodule
bind ctc_top ctc_assertions u_chk (.clock(clock), .nrst(nrst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.env(env), .ext_int(ext_int), .irq(irq));

// ===== verification/ctc_core_model.sv
// Model of the processor core run state and the time-of-day clock
`timescale 1ns/1ps
module ctc_core_model (
	// Clock
	input wire logic clock,
	// Environment to the block
	output ctc_pkg::ctc_env_t env,
	output logic [63:0] tod_value
);
	ctc_pkg::ctc_cpu_t cpu_r = ctc_pkg::CPU_OPERATING;
	ctc_pkg::ctc_tod_t tod_r = ctc_pkg::TOD_STOPPED;
	logic step_r = 1'b0;
	logic init_r = 1'b0;
	logic [63:0] tv_r = 64'h0;
	// Clock value is held by the bench so compare points stay exact
	assign env = '{cpu_r, tod_r, step_r, init_r};
	assign tod_value = tv_r;
	// One decrement unit per cycle, n cycles back to back
	task automatic step(input int n);
		repeat (n) begin
			@(posedge clock);
			step_r <= 1'b1;
		end
		@(posedge clock);
		step_r <= 1'b0;
	endtask
	// Initial processor reset, one cycle
	task automatic init_pulse;
		@(posedge clock);
		init_r <= 1'b1;
		@(posedge clock);
		init_r <= 1'b0;
	endtask
endmodule

// ===== verification/ctc_top_bench.sv
// Self-checking bench of the processor timer and clock comparator
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module ctc_top_bench;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	ctc_pkg::ctc_env_t env;
	logic [63:0] tod_value;
	ctc_pkg::ctc_ext_t ext_int;
	logic irq;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	logic [31:0] q;
	always #10 clock = ~clock;
	ctc_core_model M (.clock(clock), .env(env), .tod_value(tod_value));
	ctc_top DUT (.clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .env(env),
		.tod_value(tod_value), .ext_int(ext_int), .irq(irq));
	////////////////////////////////////////////////////////////////////////////////
	// Held request; waitrequest and read data taken at the same rising edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge clock);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		avs_byteenable <= be;
		@(posedge clock);
		while (avs_waitrequest !== 1'b0) @(posedge clock);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0, 4'hF);
		`CHK(nm, e, q)
	endtask
	// Two edges from cause to request, plus one for margin
	task automatic settle;
		repeat (3) @(posedge clock);
		@(negedge clock);
	endtask
	task automatic env_set(input ctc_pkg::ctc_cpu_t c, input ctc_pkg::ctc_tod_t t);
		@(posedge clock);
		M.cpu_r <= c;
		M.tod_r <= t;
	endtask
	task automatic tod_set(input logic [63:0] v);
		@(posedge clock);
		M.tv_r <= v;
		settle();
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Hang guard, far above the fewer than two hundred cycles of the run
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		rd(ctc_pkg::OFS_STATE, 32'h4, "state");
		rd(ctc_pkg::OFS_TMR_LO, 32'h0, "tmr_lo");
		rd(5'h02, 32'h0, "unmapped");
		wr(ctc_pkg::OFS_CTRL, 32'hFFFF_FFFF);
		rd(ctc_pkg::OFS_CTRL, 32'h0030_0001, "ctrl");
		wr(ctc_pkg::OFS_CTRL, 32'h0);
		$display("test registers done");
		wr(ctc_pkg::OFS_TMR_HI, 32'h0);
		wr(ctc_pkg::OFS_TMR_LO, 32'h3);
		M.step(3);
		rd(ctc_pkg::OFS_TMR_LO, 32'h3, "tmr stopped tod");
		env_set(ctc_pkg::CPU_STOPPED, ctc_pkg::TOD_SET);
		M.step(3);
		rd(ctc_pkg::OFS_TMR_LO, 32'h3, "tmr stopped cpu");
		env_set(ctc_pkg::CPU_WAITING, ctc_pkg::TOD_SET);
		M.step(2);
		rd(ctc_pkg::OFS_TMR_LO, 32'h1, "tmr waiting");
		env_set(ctc_pkg::CPU_OPERATING, ctc_pkg::TOD_SET);
		M.step(2);
		rd(ctc_pkg::OFS_TMR_LO, 32'hFFFF_FFFF, "tmr_lo neg");
		rd(ctc_pkg::OFS_TMR_HI, 32'hFFFF_FFFF, "tmr_hi neg");
		rd(ctc_pkg::OFS_STATUS, 32'h3, "status");
		rd(ctc_pkg::OFS_STATE, 32'hF, "state");
		// Look off the edge so a registered output is settled
		@(negedge clock);
		`CHK("ext_int", 3'h0, ext_int)
		wr(ctc_pkg::OFS_CTRL, 32'h0020_0000);
		settle();
		`CHK("ext_int", 3'h0, ext_int)
		wr(ctc_pkg::OFS_CTRL, 32'h0030_0001);
		settle();
		`CHK("ext_int", 3'h7, ext_int)
		wr(ctc_pkg::OFS_MASK, 32'h1);
		settle();
		`CHK("irq", 1'b1, irq)
		wr(ctc_pkg::OFS_STATUS, 32'h1);
		settle();
		`CHK("irq", 1'b0, irq)
		rd(ctc_pkg::OFS_STATUS, 32'h2, "status");
		$display("test timer done");
		wr(ctc_pkg::OFS_CMP_HI, 32'h0);
		wr(ctc_pkg::OFS_CMP_LO, 32'h100);
		tod_set(64'hFF);
		`CHK("ext_int", 3'h6, ext_int)
		rd(ctc_pkg::OFS_CMP_LO, 32'h100, "cmp_lo");
		rd(ctc_pkg::OFS_CMP_HI, 32'h0, "cmp_hi");
		tod_set(64'h100);
		`CHK("ext_int", 3'h7, ext_int)
		env_set(ctc_pkg::CPU_OPERATING, ctc_pkg::TOD_ERROR);
		settle();
		`CHK("ext_int", 3'h6, ext_int)
		M.init_pulse();
		settle();
		`CHK("ext_int", 3'h0, ext_int)
		// The high word reads the snapshot taken by the low-word read
		rd(ctc_pkg::OFS_TMR_LO, 32'h0, "tmr_lo");
		rd(ctc_pkg::OFS_TMR_HI, 32'h0, "tmr_hi");
		rd(ctc_pkg::OFS_CMP_LO, 32'h0, "cmp_lo");
		$display("test comparator done");
		// Checkstop holds the count; a clock that is not set still counts
		env_set(ctc_pkg::CPU_CHECKSTOP, ctc_pkg::TOD_NOT_SET);
		wr(ctc_pkg::OFS_TMR_LO, 32'h5);
		M.step(2);
		rd(ctc_pkg::OFS_TMR_LO, 32'h5, "tmr checkstop");
		env_set(ctc_pkg::CPU_OPERATING, ctc_pkg::TOD_NOT_SET);
		M.step(2);
		rd(ctc_pkg::OFS_TMR_LO, 32'h3, "tmr tod not set");
		rd(ctc_pkg::OFS_STATE, 32'hE, "state not set");
		// Only byte lane 1 of the low comparator word is written
		bus(1'b1, ctc_pkg::OFS_CMP_LO, 32'hAABB_CCDD, 4'h2);
		rd(ctc_pkg::OFS_CMP_LO, 32'h0000_CC00, "cmp_lo lane");
		$display("test modes done");
		end_of_test();
	end
endmodule
